// file: fcd_pkg.sv
package fcd_pkg;
	localparam logic [4:0] OP_SCAN_EQ     = 5'h11;
	localparam logic [4:0] OP_SCAN_HE     = 5'h1d;
	localparam logic [4:0] OP_SCAN_LE     = 5'h19;
	localparam logic [4:0] OP_VERIFY      = 5'h16;
	localparam logic [4:0] OP_WRITE       = 5'h05;
	localparam logic [7:0] OP_SEEK        = 8'h0f;
	localparam logic [7:0] OP_SENSE_DRIVE = 8'h04;
	localparam logic [7:0] OP_SENSE_INT   = 8'h08;
	localparam logic [7:0] OP_SPECIFY     = 8'h03;
	localparam logic [7:0] OP_VERSION     = 8'h10;
	localparam logic [6:0] OP_SET_TRACK   = 7'h21;
	localparam logic [3:0] SET_TRACK_PAT  = 4'h3;
	localparam logic [7:0] INVALID_ST0    = 8'h80;
	localparam logic [3:0] DATA_CMD_LEN   = 4'h9;
	localparam logic [3:0] DATA_RES_LEN   = 4'h7;
	localparam logic [3:0] STR_RESET      = 4'h0;
	localparam logic [3:0] MOFF_RESET     = 4'h0;
	localparam logic [6:0] MON_RESET      = 7'h00;
	localparam logic       DMA_RESET      = 1'b0;
	typedef enum logic [4:0] {
		ST_CMD  = 5'b00001,
		ST_SEEK = 5'b00010,
		ST_EXEC = 5'b00100,
		ST_RES  = 5'b01000,
		ST_LOAD = 5'b10000
	} fcd_state_e;
endpackage : fcd_pkg

// file: fcd_track_file.sv
`timescale 1ns/1ns
`default_nettype none
module fcd_track_file #(
	parameter int DRIVES = 4
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_drive,
	input  wire logic        wr_upper,
	input  wire logic [7:0]  wr_byte,
	input  wire logic [1:0]  rd_drive,
	output logic      [11:0] rd_track
);
	logic [11:0] track [DRIVES];
	genvar g;
	generate
		for (g = 0; g < DRIVES; g++) begin : g_drv
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					track[g] <= 12'h000;
				end else if (wr_en && wr_drive == 2'(g)) begin
					if (wr_upper)
						track[g][11:8] <= wr_byte[7:4];
					else
						track[g][7:0] <= wr_byte;
				end
			end
		end
	endgenerate
	assign rd_track = track[rd_drive];
endmodule : fcd_track_file
`default_nettype wire

// file: fcd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module fcd_decoder #(
	parameter logic [7:0] VERSION_ID = 8'h5a // Arbitrary value
) (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_byte,
	output logic            cmd_ready,
	output logic            res_valid,
	output logic      [7:0] res_byte,
	input  wire logic       res_ready,
	input  wire logic       extended_track_enable,
	input  wire logic       implied_seek_mode,
	output logic            exec_start,
	output logic      [4:0] exec_opcode,
	output logic            exec_seek,
	output logic      [11:0] seek_track,
	output logic      [1:0] exec_drive,
	output logic            head_select,
	output logic            multitrack_flag,
	output logic            density_flag,
	output logic            skip_deleted_flag,
	output logic            enable_count_flag,
	output logic            exec_to_disk,
	output logic            host_data_needed,
	output logic            compare_mode,
	input  wire logic       exec_done,
	input  wire logic [7:0] exec_st0,
	input  wire logic [7:0] exec_st1,
	input  wire logic [7:0] exec_st2,
	input  wire logic [7:0] exec_sector,
	input  wire logic [7:0] st0_pending,
	input  wire logic [7:0] drive_status_pins,
	output logic      [3:0] step_rate,
	output logic      [3:0] motor_off_time,
	output logic      [6:0] motor_on_time,
	output logic            dma_disable
);
	fcd_pkg::fcd_state_e state;
	logic [7:0]  cbuf [9];
	logic [3:0]  ccount;
	logic [3:0]  clen;
	logic [7:0]  rbuf [7];
	logic [2:0]  ridx;
	logic [2:0]  rlast;
	logic [7:0]  status_meta;
	logic [7:0]  drive_status_reg;
	logic        ext_meta;
	logic        ext_sync;
	logic        is_data;
	logic        need_seek;
	logic        tf_wr;
	logic        tf_upper;
	logic [7:0]  tf_byte;
	logic [11:0] present_track_reg;
	logic [4:0]  low5;
	logic [3:0]  next_clen;
	logic        seek_hi_wr;

	assign low5 = cbuf[0][4:0];
	assign is_data = (low5 == fcd_pkg::OP_SCAN_EQ || low5 == fcd_pkg::OP_SCAN_HE ||
	                  low5 == fcd_pkg::OP_SCAN_LE || low5 == fcd_pkg::OP_VERIFY ||
	                  (low5 == fcd_pkg::OP_WRITE && !cbuf[0][5]));
	assign cmd_ready = (state == fcd_pkg::ST_CMD);

	// Drive status and the extended track pin come from outside; synchronise first
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			status_meta <= 8'h00;
			drive_status_reg <= 8'h00;
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			status_meta <= drive_status_pins;
			drive_status_reg <= status_meta;
			ext_meta <= extended_track_enable;
			ext_sync <= ext_meta;
		end
	end

	// Length from the first byte, judged as each byte lands
	always_comb begin
		logic [7:0] b;
		b = (ccount == 4'h0) ? cmd_byte : cbuf[0];
		next_clen = 4'h1;
		if (b[4:0] == fcd_pkg::OP_SCAN_EQ || b[4:0] == fcd_pkg::OP_SCAN_HE ||
		    b[4:0] == fcd_pkg::OP_SCAN_LE || b[4:0] == fcd_pkg::OP_VERIFY ||
		    (b[4:0] == fcd_pkg::OP_WRITE && !b[5]))
			next_clen = fcd_pkg::DATA_CMD_LEN;
		else if (b == fcd_pkg::OP_SEEK)
			next_clen = ext_sync ? 4'h4 : 4'h3;
		else if (b == fcd_pkg::OP_SENSE_DRIVE || b[7] == 1'b0 && b[5:0] == 6'h21)
			next_clen = (b == fcd_pkg::OP_SENSE_DRIVE) ? 4'h2 : 4'h3;
		else if (b == fcd_pkg::OP_SPECIFY)
			next_clen = 4'h3;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 9; i++) cbuf[i] <= 8'h00;
			ccount <= 4'h0;
			clen <= 4'h1;
		end else if (state == fcd_pkg::ST_CMD && cmd_valid) begin
			cbuf[ccount] <= cmd_byte;
			clen <= next_clen;
			ccount <= (ccount + 4'h1 >= next_clen) ? 4'h0 : ccount + 4'h1;
		end
	end

	// Set track pattern 0011 0 in the second byte, else invalid
	function automatic logic set_track_ok(input logic [7:0] op, input logic [7:0] sel);
		set_track_ok = (op[7] == 1'b0 && op[5:0] == 6'h21 && sel[7:4] == fcd_pkg::SET_TRACK_PAT && !sel[3]);
	endfunction

	assign tf_wr = (state == fcd_pkg::ST_LOAD && set_track_ok(cbuf[0], cbuf[1]) && cbuf[0][6]);
	assign tf_upper = cbuf[1][2];
	assign tf_byte = tf_upper ? {cbuf[2][3:0], 4'h0} : cbuf[2];
	// Track file also stands in for the head position; seeks update it
	// Upper nibble lands a cycle after the low byte; no command can reach load that soon
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			seek_hi_wr <= 1'b0;
		end else begin
			seek_hi_wr <= exec_seek && exec_done;
		end
	end
	fcd_track_file #(.DRIVES(4)) u_track (
		.clock    (clock),
		.rstn     (rstn),
		.wr_en    (tf_wr || (exec_seek && exec_done) || seek_hi_wr),
		.wr_drive ((exec_seek || seek_hi_wr) ? exec_drive : cbuf[1][1:0]),
		.wr_upper (seek_hi_wr || (!exec_seek && tf_upper)),
		.wr_byte  (seek_hi_wr ? {seek_track[11:8], 4'h0} : exec_seek ? seek_track[7:0] : tf_byte),
		.rd_drive (exec_drive),
		.rd_track (present_track_reg)
	);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= fcd_pkg::ST_CMD;
			exec_start <= 1'b0;
			exec_seek <= 1'b0;
			need_seek <= 1'b0;
			ridx <= 3'h0;
			rlast <= 3'h0;
			for (int i = 0; i < 7; i++) rbuf[i] <= 8'h00;
		end else begin
			exec_start <= 1'b0;
			case (state)
				fcd_pkg::ST_CMD: begin
					if (cmd_valid && ccount + 4'h1 >= next_clen)
						state <= fcd_pkg::ST_LOAD;
				end
				fcd_pkg::ST_LOAD: begin
					ridx <= 3'h0;
					if (is_data) begin
						need_seek <= (cbuf[1][7] && low5 != fcd_pkg::OP_VERIFY) || implied_seek_mode;
						exec_seek <= (cbuf[1][7] && low5 != fcd_pkg::OP_VERIFY) || implied_seek_mode;
						exec_start <= 1'b1;
						state <= ((cbuf[1][7] && low5 != fcd_pkg::OP_VERIFY) || implied_seek_mode) ?
						         fcd_pkg::ST_SEEK : fcd_pkg::ST_EXEC;
					end else if (cbuf[0] == fcd_pkg::OP_SEEK) begin
						exec_seek <= 1'b1;
						exec_start <= 1'b1;
						state <= fcd_pkg::ST_SEEK;
					end else if (cbuf[0] == fcd_pkg::OP_SPECIFY) begin
						state <= fcd_pkg::ST_CMD;
					end else if (cbuf[0] == fcd_pkg::OP_SENSE_DRIVE) begin
						rbuf[0] <= drive_status_reg;
						rlast <= 3'h0;
						state <= fcd_pkg::ST_RES;
					end else if (cbuf[0] == fcd_pkg::OP_SENSE_INT) begin
						rbuf[0] <= st0_pending;
						rbuf[1] <= present_track_reg[7:0];
						rbuf[2] <= {present_track_reg[11:8], 4'h0};
						rlast <= ext_sync ? 3'h2 : 3'h1;
						state <= fcd_pkg::ST_RES;
					end else if (set_track_ok(cbuf[0], cbuf[1])) begin
						rbuf[0] <= cbuf[1][2] ? {present_track_reg[11:8], 4'h0} : present_track_reg[7:0];
						rlast <= 3'h0;
						state <= fcd_pkg::ST_RES;
					end else if (cbuf[0] == fcd_pkg::OP_VERSION) begin
						rbuf[0] <= VERSION_ID;
						rlast <= 3'h0;
						state <= fcd_pkg::ST_RES;
					end else begin
						rbuf[0] <= fcd_pkg::INVALID_ST0;
						rlast <= 3'h0;
						state <= fcd_pkg::ST_RES;
					end
				end
				fcd_pkg::ST_SEEK: begin
					if (exec_done) begin
						exec_seek <= 1'b0;
						if (need_seek) begin
							need_seek <= 1'b0;
							exec_start <= 1'b1;
							state <= fcd_pkg::ST_EXEC;
						end else begin
							state <= fcd_pkg::ST_CMD;
						end
					end
				end
				fcd_pkg::ST_EXEC: begin
					if (exec_done) begin
						rbuf[0] <= exec_st0;
						rbuf[1] <= exec_st1;
						rbuf[2] <= exec_st2;
						rbuf[3] <= cbuf[2];
						rbuf[4] <= cbuf[3];
						rbuf[5] <= exec_sector;
						rbuf[6] <= cbuf[5];
						rlast <= 3'(fcd_pkg::DATA_RES_LEN - 4'h1);
						state <= fcd_pkg::ST_RES;
					end
				end
				fcd_pkg::ST_RES: begin
					if (res_ready) begin
						ridx <= ridx + 3'h1;
						if (ridx == rlast)
							state <= fcd_pkg::ST_CMD;
					end
				end
				default: state <= fcd_pkg::ST_CMD;
			endcase
		end
	end

	assign res_valid = (state == fcd_pkg::ST_RES);
	assign res_byte = rbuf[ridx];

	// Specify registers; motor on time shares the byte with the DMA bit
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			step_rate <= fcd_pkg::STR_RESET;
			motor_off_time <= fcd_pkg::MOFF_RESET;
			motor_on_time <= fcd_pkg::MON_RESET;
			dma_disable <= fcd_pkg::DMA_RESET;
		end else if (state == fcd_pkg::ST_LOAD && cbuf[0] == fcd_pkg::OP_SPECIFY) begin
			step_rate <= cbuf[1][7:4];
			motor_off_time <= cbuf[1][3:0];
			motor_on_time <= cbuf[2][7:1];
			dma_disable <= cbuf[2][0];
		end
	end

	// Decoded fields for the execution engine
	assign exec_opcode = low5;
	assign exec_drive = cbuf[1][1:0];
	assign head_select = cbuf[1][2];
	assign multitrack_flag = cbuf[0][7];
	assign density_flag = cbuf[0][6];
	assign skip_deleted_flag = cbuf[0][5] && low5 != fcd_pkg::OP_WRITE;
	assign enable_count_flag = (low5 == fcd_pkg::OP_VERIFY) && cbuf[1][7];
	assign seek_track = (cbuf[0] == fcd_pkg::OP_SEEK) ?
	                    {(clen == 4'h4) ? cbuf[3][7:4] : 4'h0, cbuf[2]} : {4'h0, cbuf[2]};
	assign exec_to_disk = is_data && low5 == fcd_pkg::OP_WRITE;
	assign host_data_needed = is_data && low5 != fcd_pkg::OP_VERIFY;
	assign compare_mode = is_data && low5 != fcd_pkg::OP_VERIFY && low5 != fcd_pkg::OP_WRITE;

	invalid_res_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_LOAD && !is_data && cbuf[0][4:0] == 5'h1f |=> res_byte == 8'h80 && res_valid)
		else $error("invalid opcode result wrong");
	version_res_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_LOAD && cbuf[0] == 8'h10 |=> res_byte == VERSION_ID && !exec_start)
		else $error("version result wrong");
	specify_nores_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_LOAD && cbuf[0] == 8'h03 |=> state == fcd_pkg::ST_CMD ##0 step_rate == $past(cbuf[1][7:4]))
		else $error("specify handling wrong");
	seek_nores_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_SEEK && exec_done && !need_seek |=> !res_valid)
		else $error("seek produced a result");
	data_seven_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_EXEC && exec_done |=> res_valid && rlast == 3'h6 && res_byte == $past(exec_st0))
		else $error("data result length wrong");
	drive_status_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_LOAD && cbuf[0] == 8'h04 |=> res_byte == $past(drive_status_reg) && rlast == 3'h0)
		else $error("drive status result wrong");
	sense_int_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_LOAD && cbuf[0] == 8'h08 |=> res_byte == $past(st0_pending) && rlast == ($past(ext_sync) ? 3'h2 : 3'h1))
		else $error("sense interrupt result wrong");
	implied_seek_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_LOAD && is_data && implied_seek_mode |=> exec_seek && state == fcd_pkg::ST_SEEK)
		else $error("implied seek skipped");
	no_write_verify_a: assert property (@(posedge clock) disable iff (!rstn)
		low5 == fcd_pkg::OP_VERIFY |-> !host_data_needed && !exec_to_disk)
		else $error("verify moves host data");
	scan_cmp_a: assert property (@(posedge clock) disable iff (!rstn)
		state == fcd_pkg::ST_EXEC && low5 == fcd_pkg::OP_SCAN_HE |-> compare_mode && host_data_needed)
		else $error("scan compare not set");
	cov_scan_c: cover property (@(posedge clock) state == fcd_pkg::ST_EXEC && compare_mode && exec_done);
	cov_seek_c: cover property (@(posedge clock) state == fcd_pkg::ST_SEEK && exec_done);
	cov_inval_c: cover property (@(posedge clock) res_valid && res_byte == 8'h80);
endmodule : fcd_decoder
`default_nettype wire

// file: fcd_exec_model.sv
`timescale 1ns/1ns
`default_nettype none
module fcd_exec_model #(
	parameter int         DELAY  = 6,
	parameter logic [7:0] S_BASE = 8'h40
) (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       exec_start,
	input  wire logic       exec_seek,
	input  wire logic       slow,
	output logic            exec_done,
	output logic      [7:0] exec_st0,
	output logic      [7:0] exec_st1,
	output logic      [7:0] exec_st2,
	output logic      [7:0] exec_sector
);
	int   cnt;
	logic seek_q;
	// Disk work reduced to a latency; a trigger while busy is ignored so one job gives one done
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			seek_q <= 1'b0;
			exec_done <= 1'b0;
		end else begin
			seek_q <= exec_seek;
			exec_done <= (cnt == 1);
			if ((exec_start || (exec_seek && !seek_q)) && cnt == 0)
				cnt <= slow ? DELAY * 8 : DELAY;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
	// Status only valid with done; inverted otherwise so a late sample shows
	assign exec_st0    = exec_done ? S_BASE : ~S_BASE;
	assign exec_st1    = exec_done ? S_BASE + 8'h01 : ~S_BASE;
	assign exec_st2    = exec_done ? S_BASE + 8'h02 : ~S_BASE;
	assign exec_sector = exec_done ? S_BASE + 8'h03 : ~S_BASE;
endmodule : fcd_exec_model
`default_nettype wire

// file: fdc_command_decoder_scan_to_write_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module fdc_command_decoder_scan_to_write_tb_top;
	localparam logic [7:0] VID = 8'h3c; // Arbitrary value
	localparam logic [7:0] SB  = 8'h40;
	logic clock, rstn, cmd_valid, cmd_ready, res_valid, res_ready, extended_track_enable, implied_seek_mode;
	logic exec_start, exec_seek, head_select, multitrack_flag, density_flag, skip_deleted_flag, slow;
	logic enable_count_flag, exec_to_disk, host_data_needed, compare_mode, exec_done, dma_disable;
	logic [7:0]  cmd_byte, res_byte, exec_st0, exec_st1, exec_st2, exec_sector, st0_pending, drive_status_pins, b;
	logic [4:0]  exec_opcode;
	logic [1:0]  exec_drive;
	logic [11:0] seek_track;
	logic [3:0]  step_rate, motor_off_time;
	logic [6:0]  motor_on_time;
	logic [7:0]  ops [5] = '{8'hf1, 8'hdd, 8'hf9, 8'hd6, 8'hc5};
	int          n_mismatch, checks, n_done, done0;

	fcd_decoder #(.VERSION_ID(VID)) u_dut (.clock, .rstn, .cmd_valid, .cmd_byte, .cmd_ready, .res_valid,
		.res_byte, .res_ready, .extended_track_enable, .implied_seek_mode, .exec_start, .exec_opcode,
		.exec_seek, .seek_track, .exec_drive, .head_select, .multitrack_flag, .density_flag,
		.skip_deleted_flag, .enable_count_flag, .exec_to_disk, .host_data_needed, .compare_mode, .exec_done,
		.exec_st0, .exec_st1, .exec_st2, .exec_sector, .st0_pending, .drive_status_pins, .step_rate,
		.motor_off_time, .motor_on_time, .dma_disable);
	fcd_exec_model #(.S_BASE(SB)) u_model (.clock, .rstn, .exec_start, .exec_seek, .slow, .exec_done,
		.exec_st0, .exec_st1, .exec_st2, .exec_sector);

	always #5 clock = ~clock;
	always @(negedge clock) begin
		if (exec_done === 1'b1) n_done++;
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk
	// Request held from just after an edge until the edge that takes it
	task send(input logic [7:0] v, input bit last);
		int n;
		cmd_valid = 1'b1;
		cmd_byte = v;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 500) begin
			@(posedge clock); #1; n++;
		end
		if (n == 500) n_mismatch++;
		@(posedge clock); #1;
		if (last) begin
			cmd_valid = 1'b0;
			cmd_byte = ~v;
		end
	endtask : send
	task cmd(input logic [7:0] q[$]);
		@(posedge clock); #1;
		foreach (q[i]) send(q[i], i == q.size() - 1);
	endtask : cmd
	task get(input logic [7:0] exp, input bit use_it, input bit last);
		int n;
		res_ready = 1'b1;
		n = 0;
		while (res_valid !== 1'b1 && n < 500) begin
			@(posedge clock); #1; n++;
		end
		if (n == 500) n_mismatch++;
		if (use_it) chk(res_byte, exp);
		@(posedge clock); #1;
		if (last) res_ready = 1'b0;
	endtask : get
	task res(input logic [7:0] q[$]);
		foreach (q[i]) get(q[i], 1'b1, i == q.size() - 1);
	endtask : res
	task wait_hi(input bit done_sig);
		int n;
		n = 0;
		while ((done_sig ? exec_done : exec_start) !== 1'b1 && n < 500) begin
			@(posedge clock); #1; n++;
		end
		if (n == 500) n_mismatch++;
	endtask : wait_hi
	// Nothing pending: no result offered and commands accepted again
	task idle_chk;
		repeat (3) @(posedge clock);
		#1;
		chk({6'h0, res_valid, cmd_ready}, 8'h01);
	endtask : idle_chk
	task end_of_test;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		#400000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		{clock, rstn, cmd_valid, res_ready, extended_track_enable, implied_seek_mode, slow} = 7'h0;
		cmd_byte = 8'h00;
		st0_pending = 8'h20;
		drive_status_pins = 8'h2b;
		repeat (2) @(posedge clock);
		#1 rstn = 1'b1;
		cmd('{8'h10});
		repeat (4) @(posedge clock);
		#1;
		chk({7'h0, res_valid}, 8'h01);
		get(VID, 1'b1, 1'b1);
		cmd('{8'hff});
		get(8'h80, 1'b1, 1'b1);
		cmd('{8'h03, 8'ha5, 8'h57});
		idle_chk();
		chk({step_rate, motor_off_time}, 8'ha5);
		chk({motor_on_time, dma_disable}, 8'h57);
		cmd('{8'h0f, 8'h05, 8'h42});
		wait_hi(1'b1);
		chk({2'h0, exec_drive, 3'h0, head_select}, 8'h11);
		chk(seek_track[7:0], 8'h42);
		idle_chk();
		cmd('{8'h08});
		res('{8'h20, 8'h42});
		idle_chk();
		extended_track_enable = 1'b1;
		cmd('{8'h0f, 8'h02, 8'h34, 8'h70});
		wait_hi(1'b1);
		chk({4'h0, seek_track[11:8]}, 8'h07);
		cmd('{8'h08});
		res('{8'h20, 8'h34, 8'h70});
		extended_track_enable = 1'b0;
		cmd('{8'h04, 8'h01});
		get(8'h2b, 1'b1, 1'b1);
		cmd('{8'h61, 8'h32, 8'h9c});
		get(8'h00, 1'b0, 1'b1);
		cmd('{8'h21, 8'h32, 8'h00});
		get(8'h9c, 1'b1, 1'b1);
		for (int i = 0; i < 5; i++) begin
			b = ops[i];
			cmd('{b, (i == 3) ? 8'h86 : 8'h06, 8'h10 + i[7:0], 8'h01, 8'h03, 8'h02, 8'h09, 8'h1b, 8'hff});
			wait_hi(1'b0);
			chk({exec_drive, 1'b0, exec_opcode}, {2'd2, 1'b0, b[4:0]});
			chk({compare_mode, host_data_needed, exec_to_disk, multitrack_flag, density_flag, skip_deleted_flag,
				head_select, enable_count_flag}, {i < 3, i != 3, i == 4, b[7:5], 1'b1, i == 3});
			res('{SB, SB + 8'h01, SB + 8'h02, 8'h10 + i[7:0], 8'h01, SB + 8'h03, 8'h02});
		end
		done0 = n_done;
		slow = 1'b1;
		cmd('{8'hc5, 8'h86, 8'h55, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1b, 8'hff});
		res('{SB, SB + 8'h01, SB + 8'h02, 8'h55, 8'h00, SB + 8'h03, 8'h02});
		chk(8'(n_done - done0), 8'h02);
		// Mode pin alone asks for the seek, here on a verify without the flag bit
		implied_seek_mode = 1'b1;
		done0 = n_done;
		cmd('{8'hd6, 8'h06, 8'h27, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1b, 8'hff});
		wait_hi(1'b0);
		chk({7'h0, exec_seek}, 8'h01);
		res('{SB, SB + 8'h01, SB + 8'h02, 8'h27, 8'h00, SB + 8'h03, 8'h02});
		chk(8'(n_done - done0), 8'h02);
		implied_seek_mode = 1'b0;
		cmd('{8'h21, 8'h32, 8'h00});
		get(8'h27, 1'b1, 1'b1);
		end_of_test();
	end
endmodule : fdc_command_decoder_scan_to_write_tb_top
`default_nettype wire
